/* File: inc/acc_defs.vh */
// constants for the converter control block: module addresses, field
// positions, reset values and timing counts. definitions only.
// Summary of operation
// - registers decode at module addresses 00h to 09h as mapped below.
// - three result registers are read only, each holding its latest result.
// - reset clears all registers to 0000h, setup_b registers take 0070h.
// - command bits 11..8 select single-ended source; bits 15..12, 7..3 unused.
// - command bit 2 starts channel 1 conversion into chan1 result.
// - command bit 1 starts channel 2 conversion into chan2 result.
// - command bit 0 starts temperature conversion into temp result.
// - processor is held halted while any conversion runs.
// - finishing a conversion clears all three start bits, including the one that launched it.
// - channel 1 beats channel 2 beats temperature; only winner converts.
// - selector zero makes channel requests convert the differential pair.
// - temperature request with nonzero selector only clears its start bit and stores nothing.
// - nonzero selector converts chosen single-ended source into channel result.
// - access starts by control bit 15, bit 14 reads; bit 15 self-clears.
// - only low 8 address bits decode a register.
// - reads overwrite the data port, writes leave it unchanged.
`ifndef ACC_DEFS_VH
`define ACC_DEFS_VH
`define ACC_ADDR_CMD 8'h00
`define ACC_ADDR_RES1 8'h01
`define ACC_ADDR_C1A 8'h02
`define ACC_ADDR_C1B 8'h03
`define ACC_ADDR_RES2 8'h04
`define ACC_ADDR_C2A 8'h05
`define ACC_ADDR_C2B 8'h06
`define ACC_ADDR_REST 8'h07
`define ACC_ADDR_CTA 8'h08
`define ACC_ADDR_CTB 8'h09
`define ACC_RST_ZERO 16'h0000
`define ACC_RST_SETUP_B 16'h0070
`define ACC_CMD_MASK 16'h0f07
`define ACC_SETUP_A_MASK 16'hff7f
`define ACC_SETUP_B_MASK 16'h0073
`define ACC_SETUP_TB_MASK 16'h0070
`define ACC_BIT_CHAN1 2
`define ACC_BIT_CHAN2 1
`define ACC_BIT_TEMP 0
`define ACC_SEL_HI 11
`define ACC_SEL_LO 8
`define ACC_CTL_GO 15
`define ACC_CTL_RD 14
`define ACC_CONV_TIME_NS 2000
`define ACC_CLK_NS 40
`define ACC_CONV_CYC ((`ACC_CONV_TIME_NS + `ACC_CLK_NS - 1) / `ACC_CLK_NS)
`endif

/* File: hw/acc_result_mem.v */
// four-word result store, read data registered.
// assumes one clock domain; single write and single read port.
`timescale 1ns/1ps
module acc_result_mem
(
    // clock and reset
    input wire clk_i,
    input wire rst_b_i,
    // write side
    input wire wr_en_i,
    input wire [1:0] wr_idx_i,
    input wire [15:0] wr_data_i,
    // read side
    input wire [1:0] rd_idx_i,
    output reg [15:0] rd_data_o
);
    reg [15:0] mem [0:3];
    integer k;

    // results clear at reset so reads are defined from the start
    always @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            for (k = 0; k < 4; k = k + 1)
                mem[k] <= 16'h0000;
            rd_data_o <= 16'h0000;
        end
        else
        begin
            if (wr_en_i)
                mem[wr_idx_i] <= wr_data_i;
            rd_data_o <= mem[rd_idx_i];
        end
    end
endmodule

/* File: hw/acc_top.v */
// converter control: module register file, start logic and cpu halt.
// assumes the cpu ports arrive from same-clock logic and the converter
// core returns its sample on conv_data_i with a single-cycle valid.
`timescale 1ns/1ps
`include "acc_defs.vh"
module acc_top
(
    // clock and reset
    input wire clk_i,
    input wire rst_b_i,
    // cpu module ports
    input wire [15:0] module_addr_port_i,
    input wire [15:0] module_ctl_port_i,
    input wire module_ctl_we_i,
    input wire [15:0] module_data_port_i,
    output reg [15:0] module_data_port_o,
    output reg module_data_load_o,
    output reg module_ctl_clear_o,
    // cpu halt
    output reg cpu_halt_o,
    // converter core
    output reg conv_start_o,
    output reg [1:0] conv_chan_o,
    output reg [3:0] conv_source_o,
    output reg [15:0] conv_setup_a_o,
    output reg [15:0] conv_setup_b_o,
    input wire conv_valid_i,
    input wire [15:0] conv_data_i
);
    localparam ST_IDLE = 2'd0;
    localparam ST_CONV = 2'd1;
    localparam ST_READ = 2'd2;
    localparam CH_1 = 2'd1;
    localparam CH_2 = 2'd2;
    localparam CH_T = 2'd3;

    reg [15:0] conversion_command;
    reg [15:0] chan1_setup_a;
    reg [15:0] chan1_setup_b;
    reg [15:0] chan2_setup_a;
    reg [15:0] chan2_setup_b;
    reg [15:0] temp_setup_a;
    reg [15:0] temp_setup_b;
    reg [1:0] state;
    reg [1:0] active_chan;
    reg [7:0] conv_cnt;
    reg [7:0] read_addr;
    reg [15:0] read_word;
    reg read_is_result;
    reg [1:0] res_idx;
    reg res_wr;
    reg [15:0] res_data;
    reg [1:0] next_chan;
    reg access_go;
    wire [15:0] res_rd_data;
    wire [3:0] source_select;
    wire start_chan1;
    wire start_chan2;
    wire start_temp;
    wire [7:0] ctl_addr;

    // result registers sit in the small store, index = channel code
    acc_result_mem u_res
    (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .wr_en_i(res_wr),
        .wr_idx_i(res_idx),
        .wr_data_i(res_data),
        .rd_idx_i(next_res_idx(module_addr_port_i[7:0])),
        .rd_data_o(res_rd_data)
    );

    // maps a module address to its result slot, zero if none
    function [1:0] next_res_idx;
        input [7:0] a;
        begin
            if (a == `ACC_ADDR_RES1)
                next_res_idx = CH_1;
            else if (a == `ACC_ADDR_RES2)
                next_res_idx = CH_2;
            else if (a == `ACC_ADDR_REST)
                next_res_idx = CH_T;
            else
                next_res_idx = 2'd0;
        end
    endfunction

    assign ctl_addr = module_addr_port_i[7:0];
    assign source_select = conversion_command[`ACC_SEL_HI:`ACC_SEL_LO];
    assign start_chan1 = conversion_command[`ACC_BIT_CHAN1];
    assign start_chan2 = conversion_command[`ACC_BIT_CHAN2];
    assign start_temp = conversion_command[`ACC_BIT_TEMP];

    // priority pick of the pending request
    always @*
    begin
        next_chan = 2'd0;
        if (start_chan1)
            next_chan = CH_1;
        else if (start_chan2)
            next_chan = CH_2;
        else if (start_temp && source_select == 4'h0)
            next_chan = CH_T;
    end

    // an access is taken when the cpu writes control with the go bit set
    always @*
    begin
        access_go = module_ctl_we_i && module_ctl_port_i[`ACC_CTL_GO];
    end

    // non-result read mux; result words come from the store a cycle later
    always @*
    begin
        read_word = 16'h0000;
        if (read_addr == `ACC_ADDR_CMD)
            read_word = conversion_command;
        else if (read_addr == `ACC_ADDR_C1A)
            read_word = chan1_setup_a;
        else if (read_addr == `ACC_ADDR_C1B)
            read_word = chan1_setup_b;
        else if (read_addr == `ACC_ADDR_C2A)
            read_word = chan2_setup_a;
        else if (read_addr == `ACC_ADDR_C2B)
            read_word = chan2_setup_b;
        else if (read_addr == `ACC_ADDR_CTA)
            read_word = temp_setup_a;
        else if (read_addr == `ACC_ADDR_CTB)
            read_word = temp_setup_b;
        else if (read_is_result)
            read_word = res_rd_data;
    end

    // main sequencer: register access, conversion launch and completion
    always @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            conversion_command <= `ACC_RST_ZERO;
            chan1_setup_a <= `ACC_RST_ZERO;
            chan1_setup_b <= `ACC_RST_SETUP_B;
            chan2_setup_a <= `ACC_RST_ZERO;
            chan2_setup_b <= `ACC_RST_SETUP_B;
            temp_setup_a <= `ACC_RST_ZERO;
            temp_setup_b <= `ACC_RST_SETUP_B;
            state <= ST_IDLE;
            active_chan <= 2'd0;
            conv_cnt <= 8'h00;
            read_addr <= 8'h00;
            read_is_result <= 1'b0;
            res_idx <= 2'd0;
            res_wr <= 1'b0;
            res_data <= 16'h0000;
            module_data_port_o <= 16'h0000;
            module_data_load_o <= 1'b0;
            module_ctl_clear_o <= 1'b0;
            cpu_halt_o <= 1'b0;
            conv_start_o <= 1'b0;
            conv_chan_o <= 2'd0;
            conv_source_o <= 4'h0;
            conv_setup_a_o <= 16'h0000;
            conv_setup_b_o <= 16'h0000;
        end
        else
        begin
            res_wr <= 1'b0;
            conv_start_o <= 1'b0;
            module_data_load_o <= 1'b0;
            module_ctl_clear_o <= 1'b0;
            case (state)
            ST_IDLE:
            begin
                if (access_go && module_ctl_port_i[`ACC_CTL_RD])
                begin
                    // read takes two cycles for the registered store
                    read_addr <= ctl_addr;
                    read_is_result <= (next_res_idx(ctl_addr) != 2'd0);
                    state <= ST_READ;
                end
                else if (access_go)
                begin
                    module_ctl_clear_o <= 1'b1;
                    // writes leave the data port as is
                    if (ctl_addr == `ACC_ADDR_CMD)
                        conversion_command <= module_data_port_i & `ACC_CMD_MASK;
                    else if (ctl_addr == `ACC_ADDR_C1A)
                        chan1_setup_a <= module_data_port_i & `ACC_SETUP_A_MASK;
                    else if (ctl_addr == `ACC_ADDR_C1B)
                        chan1_setup_b <= module_data_port_i & `ACC_SETUP_B_MASK;
                    else if (ctl_addr == `ACC_ADDR_C2A)
                        chan2_setup_a <= module_data_port_i & `ACC_SETUP_A_MASK;
                    else if (ctl_addr == `ACC_ADDR_C2B)
                        chan2_setup_b <= module_data_port_i & `ACC_SETUP_B_MASK;
                    else if (ctl_addr == `ACC_ADDR_CTA)
                        temp_setup_a <= module_data_port_i & `ACC_SETUP_A_MASK;
                    else if (ctl_addr == `ACC_ADDR_CTB)
                        temp_setup_b <= module_data_port_i & `ACC_SETUP_TB_MASK;
                end
                else if (next_chan != 2'd0)
                begin
                    // launch winner; halt holds the cpu until done
                    active_chan <= next_chan;
                    conv_chan_o <= next_chan;
                    conv_source_o <= source_select;
                    conv_start_o <= 1'b1;
                    cpu_halt_o <= 1'b1;
                    conv_cnt <= 8'h00;
                    state <= ST_CONV;
                    if (next_chan == CH_1)
                    begin
                        conv_setup_a_o <= chan1_setup_a;
                        conv_setup_b_o <= chan1_setup_b;
                    end
                    else if (next_chan == CH_2)
                    begin
                        conv_setup_a_o <= chan2_setup_a;
                        conv_setup_b_o <= chan2_setup_b;
                    end
                    else
                    begin
                        conv_setup_a_o <= temp_setup_a;
                        conv_setup_b_o <= temp_setup_b;
                    end
                end
                else if (start_temp)
                    conversion_command[`ACC_BIT_TEMP] <= 1'b0;
            end
            ST_CONV:
            begin
                // floor time guards against a core that answers too early
                if (conv_cnt < `ACC_CONV_CYC)
                    conv_cnt <= conv_cnt + 8'h01;
                else if (conv_valid_i)
                begin
                    // done: release halt and drop all three start bits together
                    res_wr <= 1'b1;
                    res_idx <= active_chan;
                    res_data <= conv_data_i;
                    cpu_halt_o <= 1'b0;
                    state <= ST_IDLE;
                    // a lower request still pending is dropped; only winner runs
                    conversion_command[`ACC_BIT_CHAN1] <= 1'b0;
                    conversion_command[`ACC_BIT_CHAN2] <= 1'b0;
                    conversion_command[`ACC_BIT_TEMP] <= 1'b0;
                end
            end
            ST_READ:
            begin
                module_data_port_o <= read_word;
                module_data_load_o <= 1'b1;
                module_ctl_clear_o <= 1'b1;
                state <= ST_IDLE;
            end
            default:
                state <= ST_IDLE;
            endcase
        end
    end
endmodule

/* File: sim/acc_chk.sv */
// checker: access answers, halt timing and pulse shapes of acc_top.
// assumes a bind onto acc_top, one clock, sync active-low reset.
`timescale 1ns/1ps
module acc_chk
(
    // clock and reset
    input logic clk_i,
    input logic rst_b_i,
    // cpu side
    input logic [15:0] module_addr_port_i,
    input logic [15:0] module_ctl_port_i,
    input logic module_ctl_we_i,
    input logic [15:0] module_data_port_i,
    input logic [15:0] module_data_port_o,
    input logic module_data_load_o,
    input logic module_ctl_clear_o,
    input logic cpu_halt_o,
    // core side
    input logic conv_start_o,
    input logic [1:0] conv_chan_o,
    input logic [3:0] conv_source_o,
    input logic [15:0] conv_setup_a_o,
    input logic [15:0] conv_setup_b_o,
    input logic conv_valid_i,
    input logic [15:0] conv_data_i
);
    // floor less two cycles of pipeline slack between start and release
    localparam int CONV_MIN = 48;
    logic [7:0] halt_cnt;
    logic take;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    // an access the block must take: go bit written while idle
    assign take = module_ctl_we_i && module_ctl_port_i[15] && !cpu_halt_o;
    // halt length, saturating so a long stall cannot wrap
    always @(posedge clk_i)
        if (!rst_b_i || !cpu_halt_o)
            halt_cnt <= 8'h00;
        else if (halt_cnt != 8'hff)
            halt_cnt <= halt_cnt + 8'h01;
    a_write_answer: assert property (take && !module_ctl_port_i[14]
        |=> module_ctl_clear_o && !module_data_load_o) else $error("write not answered");
    a_read_answer: assert property (take && module_ctl_port_i[14]
        |=> !module_ctl_clear_o ##1 (module_ctl_clear_o && module_data_load_o))
        else $error("read not answered");
    a_load_single: assert property (module_data_load_o |=> !module_data_load_o)
        else $error("load longer than one cycle");
    a_start_halt: assert property (conv_start_o |-> cpu_halt_o && conv_chan_o != 2'h0)
        else $error("start without halt");
    a_start_once: assert property (cpu_halt_o && $past(cpu_halt_o) |-> !conv_start_o)
        else $error("second start in one conversion");
    a_halt_floor: assert property ($fell(cpu_halt_o) |-> halt_cnt >= CONV_MIN)
        else $error("halt released too early");
    a_halt_release: assert property (cpu_halt_o && conv_valid_i |=> !cpu_halt_o)
        else $error("halt kept after result");
    a_halt_refuse: assert property (cpu_halt_o && $past(cpu_halt_o) && module_ctl_we_i
        |=> (!module_ctl_clear_o)[*2]) else $error("access taken while halted");
    a_temp_source: assert property (conv_start_o && conv_chan_o == 2'h3
        |-> conv_source_o == 4'h0) else $error("temperature start with source set");
    a_reset_quiet: assert property (disable iff (1'b0) !rst_b_i
        |=> !cpu_halt_o && !conv_start_o && !module_ctl_clear_o) else $error("busy after reset");
endmodule

bind acc_top acc_chk u_acc_chk
(
    .clk_i, .rst_b_i, .module_addr_port_i, .module_ctl_port_i, .module_ctl_we_i,
    .module_data_port_i, .module_data_port_o, .module_data_load_o, .module_ctl_clear_o,
    .cpu_halt_o, .conv_start_o, .conv_chan_o, .conv_source_o, .conv_setup_a_o,
    .conv_setup_b_o, .conv_valid_i, .conv_data_i
);

/* File: sim/acc_core_model.sv */
// converter core stand-in: answers each start with one valid pulse.
// assumes start is a one-cycle pulse and no new start before the answer.
`timescale 1ns/1ps
module acc_core_model
(
    // clock and reset
    input logic clk_i,
    input logic rst_b_i,
    // request from the block
    input logic start_i,
    input logic [1:0] chan_i,
    input logic [3:0] source_i,
    input logic [15:0] setup_a_i,
    input logic [15:0] setup_b_i,
    input logic [7:0] delay_i,
    // answer
    output logic valid_o,
    output logic [15:0] data_o
);
    logic [7:0] cnt;
    logic [15:0] held = 16'h0000;
    // result is a fingerprint of the request, so the bench can tell
    // which setup pair and source went with the start
    always @(posedge clk_i)
        if (!rst_b_i)
        begin
            cnt <= 8'h00;
            valid_o <= 1'b0;
        end
        else if (start_i)
        begin
            cnt <= delay_i;
            held <= {chan_i, setup_b_i[1:0], source_i, setup_a_i[7:0]};
            valid_o <= 1'b0;
        end
        else
        begin
            cnt <= (cnt != 8'h00) ? cnt - 8'h01 : 8'h00;
            valid_o <= (cnt == 8'h01);
        end
    // outside the valid cycle the data lines show garbage, not the result
    assign data_o = valid_o ? held : ~held;
endmodule

/* File: sim/acc_top_test.sv */
// self-checking bench for acc_top: register map, start bits and halt.
// assumes acc_core_model on the core side; cpu ports driven here.
`timescale 1ns/1ps
module acc_top_test;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [15:0] addr = 16'h0000, ctl = 16'h0000, wdat = 16'h0000, r, rdat, sa, sb, cdat;
    logic we = 1'b0;
    logic [7:0] delay = 8'h37;
    logic load, clear, halt, start, valid;
    logic [1:0] chan, c;
    logic [3:0] src;
    logic [15:0] res [1:3] = '{16'h0000, 16'h0000, 16'h0000};
    logic [15:0] mask [0:9] = '{16'h0f07, 16'h0000, 16'hff7f, 16'h0073, 16'h0000,
        16'hff7f, 16'h0073, 16'h0000, 16'hff7f, 16'h0070};
    logic [15:0] cmd [0:7] = '{16'h0004, 16'h0002, 16'h0001, 16'h0007, 16'h0003,
        16'h0501, 16'hf8fe, 16'h0303};
    logic [7:0] sal [1:3] = '{8'h72, 8'h75, 8'h78};
    logic [1:0] sbl [1:3] = '{2'h3, 2'h2, 2'h0};
    int n_errors = 0, comparisons = 0, i, j, k;
    acc_top u_acc_top (.clk_i(clk_i), .rst_b_i(rst_b_i), .module_addr_port_i(addr),
        .module_ctl_port_i(ctl), .module_ctl_we_i(we), .module_data_port_i(wdat),
        .module_data_port_o(rdat), .module_data_load_o(load), .module_ctl_clear_o(clear),
        .cpu_halt_o(halt), .conv_start_o(start), .conv_chan_o(chan), .conv_source_o(src),
        .conv_setup_a_o(sa), .conv_setup_b_o(sb), .conv_valid_i(valid), .conv_data_i(cdat));
    acc_core_model u_acc_core_model (.clk_i(clk_i), .rst_b_i(rst_b_i), .start_i(start),
        .chan_i(chan), .source_i(src), .setup_a_i(sa), .setup_b_i(sb), .delay_i(delay),
        .valid_o(valid), .data_o(cdat));
    initial
        forever #20 clk_i = ~clk_i;
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // one module access; returns at the edge where the clear pulse is seen
    task automatic acc(input logic rd, input logic [15:0] a, input logic [15:0] w);
        int n;
        addr <= a;
        wdat <= w;
        ctl <= {1'b1, rd, 14'h0000};
        we <= 1'b1;
        @(posedge clk_i);
        we <= 1'b0;
        n = 0;
        while (clear !== 1'b1 && n < 100)
        begin
            @(posedge clk_i);
            n++;
        end
        r = rdat;
        if (n == 100)
            chk("access answer", 16'h0000, 16'h0001);
    endtask
    task automatic rdc(input logic [15:0] a, input logic [15:0] e);
        acc(1'b1, a, 16'h0000);
        chk("read data", r, e);
    endtask
    task automatic end_sim();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        repeat (4) @(posedge clk_i);
        rst_b_i <= 1'b1;
        @(posedge clk_i);
        // reset values with junk in the upper address byte, 0ah unmapped
        for (i = 0; i < 11; i++)
            rdc(16'hab00 | i[15:0], (i % 3 == 0 && i > 0 && i < 10) ? 16'h0070 : 16'h0000);
        for (i = 1; i < 10; i++)
            acc(1'b0, i[15:0], 16'hfff0 | i[15:0]);
        for (i = 1; i < 10; i++)
            rdc(i[15:0], (16'hfff0 | i[15:0]) & mask[i]);
        acc(1'b0, 16'h0002, 16'hfff2);
        chk("data port after write", rdat, 16'h0070);
        // each start pattern, alternating prompt and slow core answers
        for (i = 0; i < 8; i++)
        begin
            delay <= (i % 2) ? 8'h5a : 8'h37;
            acc(1'b0, 16'h0000, cmd[i]);
            c = cmd[i][2] ? 2'h1 : cmd[i][1] ? 2'h2 : (cmd[i][0] && cmd[i][11:8] == 4'h0) ? 2'h3 : 2'h0;
            if (c != 2'h0)
                res[c] = {c, sbl[c], cmd[i][11:8], sal[c]};
            repeat (3) @(posedge clk_i);
            chk("halt", {15'h0000, halt}, {15'h0000, c != 2'h0});
            // a read pushed in mid conversion must be ignored
            we <= 1'b1;
            ctl <= 16'hc000;
            @(posedge clk_i);
            we <= 1'b0;
            k = 0;
            while (halt !== 1'b0 && k < 200)
            begin
                @(posedge clk_i);
                k++;
            end
            chk("halt released", k[15:0] < 16'h00c8, 1'b1);
            repeat (3) @(posedge clk_i);
            rdc(16'h0000, cmd[i] & 16'h0f00);
            for (j = 1; j < 4; j++)
                rdc(16'(j * 3 - 2), res[j]);
        end
        end_sim();
    end
    // watchdog: the whole run needs under a thousand cycles
    initial
    begin
        #(40 * 20000);
        n_errors++;
        end_sim();
    end
endmodule
